// ### maskable_interrupt_sequencer_tb.sv
`timescale 1ns/10ps
module maskable_interrupt_sequencer_tb
  import mis_pkg::*;
;
  logic ref_clk_i = 1'b0, reset_i = 1'b1, slow = 1'b0;
  logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, trap_i = 1'b0;
  logic skip_next_i = 1'b0, psw_wr_i = 1'b0, psw_gie_i = 1'b0;
  logic vis_exec_i = 1'b0, return_from_interrupt_i = 1'b0;
  logic [NUM_SRC-1:0] src_event_i = '0;
  logic [PC_W-1:0] pc_next_i, pop_addr_i, push_addr_o, pc_value_o;
  logic insn_start_i, pop_valid_i, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, irq_take_o;
  logic ack_busy_o, push_valid_o, pop_req_o, pc_load_o, vis_valid_o;
  logic global_interrupt_enable_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [7:0] vis_low_byte_o;
  int fail_count = 0, check_count = 0;

  always #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;

  mis_sequencer i_mis_sequencer (
    .ref_clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .src_event_i, .trap_i, .insn_start_i,
    .skip_next_i, .pc_next_i, .psw_wr_i, .psw_gie_i, .vis_exec_i,
    .return_from_interrupt_i, .pop_valid_i, .pop_addr_i, .irq_take_o,
    .ack_busy_o, .push_valid_o, .push_addr_o, .pop_req_o, .pc_load_o,
    .pc_value_o, .vis_valid_o, .vis_low_byte_o, .global_interrupt_enable_o
  );

  mis_core_model i_mis_core_model (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .slow_i(slow),
    .push_valid_i(push_valid_o), .push_addr_i(push_addr_o),
    .pop_req_i(pop_req_o), .pc_load_i(pc_load_o), .pc_value_i(pc_value_o),
    .insn_start_o(insn_start_i), .pc_next_o(pc_next_i),
    .pop_valid_o(pop_valid_i), .pop_addr_o(pop_addr_i)
  );

  task automatic chk(input string n, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(negedge ref_clk_i);
      ta = s_axi_awvalid_i & s_axi_awready_o;
      tw = s_axi_wvalid_i & s_axi_wready_o;
      tb = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge ref_clk_i);
      if (ta) s_axi_awvalid_i <= 1'b0;
      if (tw) s_axi_wvalid_i <= 1'b0;
    end while (tb !== 1'b1);
    s_axi_bready_i <= 1'b0;
    chk("bresp", 32'(r), 32'(RESP_OKAY));
  endtask : axw

  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    logic ta, tr;
    logic [1:0] r;
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(negedge ref_clk_i);
      ta = s_axi_arvalid_i & s_axi_arready_o;
      tr = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge ref_clk_i);
      if (ta) s_axi_arvalid_i <= 1'b0;
    end while (tr !== 1'b1);
    s_axi_rready_i <= 1'b0;
    chk("rresp", 32'(r), 32'(RESP_OKAY));
  endtask : axr

  task automatic wait_cnt(input bit load, input int lim, output int c);
    c = 0;
    do begin
      @(negedge ref_clk_i);
      c++;
    end while ((load ? pc_load_o : irq_take_o) !== 1'b1 && c < lim);
  endtask : wait_cnt

  // Expects an acknowledge or its absence over three boundaries
  task automatic take(input logic e, output logic [PC_W-1:0] pa);
    int c;
    wait_cnt(1'b0, 48, c);
    chk("take", 32'(irq_take_o), 32'(e));
    pa = push_addr_o;
    if (irq_take_o === 1'b1) begin
      chk("gie_clear", 32'(global_interrupt_enable_o), 32'h0);
      wait_cnt(1'b1, 800, c);
      chk("ack_len", c, ACK_CLKS);
      chk("handler", 32'(pc_value_o), 32'(HANDLER_ADDR));
    end
  endtask : take

  task automatic vector_select_instruction(input logic [7:0] e);
    @(posedge ref_clk_i);
    vis_exec_i <= 1'b1;
    @(posedge ref_clk_i);
    vis_exec_i <= 1'b0;
    @(negedge ref_clk_i);
    chk("vis_byte", 32'(vis_low_byte_o), 32'(e));
  endtask : vector_select_instruction

  task automatic ret(input logic [PC_W-1:0] pa);
    int c;
    @(posedge ref_clk_i);
    return_from_interrupt_i <= 1'b1;
    @(posedge ref_clk_i);
    return_from_interrupt_i <= 1'b0;
    wait_cnt(1'b1, 100, c);
    chk("ret_pc", 32'(pc_value_o), 32'(pa));
    chk("ret_gie", 32'(global_interrupt_enable_o), 32'h1);
  endtask : ret

  task automatic ev(input logic [NUM_SRC-1:0] m, input logic t);
    @(posedge ref_clk_i);
    src_event_i <= m;
    trap_i <= t;
    @(posedge ref_clk_i);
    src_event_i <= '0;
    trap_i <= 1'b0;
  endtask : ev

  task automatic t_order;
    logic [31:0] d;
    logic [PC_W-1:0] pa;
    axr(ADDR_PENDING, d);
    chk("rst_pend", d, 32'h0);
    ev(11'h024, 1'b0);
    axw(ADDR_ENABLE, 32'h24);
    take(1'b0, pa);
    axr(ADDR_STATUS, d);
    chk("active", d & 32'h7FF, 32'h24);
    axw(ADDR_CTRL, 32'h1);
    take(1'b1, pa);
    vector_select_instruction(VEC_TABLE[2]);
    axw(ADDR_PENDING, 32'h4);
    axr(ADDR_PENDING, d);
    chk("left", d, 32'h20);
    slow <= 1'b1;
    ret(pa);
    take(1'b1, pa);
    vector_select_instruction(VEC_TABLE[5]);
    axw(ADDR_PENDING, 32'h20);
    slow <= 1'b0;
    ret(pa);
  endtask : t_order

  task automatic t_trap;
    logic [PC_W-1:0] pa, pb;
    axw(ADDR_CTRL, 32'h0);
    axw(ADDR_ENABLE, 32'h1);
    ev(11'h001, 1'b1);
    take(1'b1, pa);
    vector_select_instruction(VEC_TRAP);
    @(posedge ref_clk_i);
    psw_wr_i <= 1'b1;
    psw_gie_i <= 1'b1;
    @(posedge ref_clk_i);
    psw_wr_i <= 1'b0;
    take(1'b0, pb);
    chk("psw_gie", 32'(global_interrupt_enable_o), 32'h1);
    @(posedge ref_clk_i);
    skip_next_i <= 1'b1;
    ret(pa);
    take(1'b0, pb);
    @(posedge ref_clk_i);
    skip_next_i <= 1'b0;
    take(1'b1, pa);
    vector_select_instruction(VEC_TABLE[0]);
    axw(ADDR_PENDING, 32'h1);
    ret(pa);
    vector_select_instruction(VEC_DEFAULT);
  endtask : t_trap

  initial begin
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_order();
    t_trap();
    results();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    results();
  end
endmodule : maskable_interrupt_sequencer_tb

// ### mis_core_model.sv
`timescale 1ns/10ps
module mis_core_model
  import mis_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic slow_i,
  input wire logic push_valid_i,
  input wire logic [PC_W-1:0] push_addr_i,
  input wire logic pop_req_i,
  input wire logic pc_load_i,
  input wire logic [PC_W-1:0] pc_value_i,
  output logic insn_start_o,
  output logic [PC_W-1:0] pc_next_o,
  output logic pop_valid_o,
  output logic [PC_W-1:0] pop_addr_o
);
  logic [PC_W-1:0] stack_q[$];
  int gap_q, pop_q;
  // Boundaries keep coming during a sequence, as a busy core may signal
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_q <= 0;
      pop_q <= 0;
      insn_start_o <= 1'b0;
      pc_next_o <= 15'h0100;
      pop_valid_o <= 1'b0;
      pop_addr_o <= '0;
      stack_q.delete();
    end else begin
      gap_q <= (gap_q == 15) ? 0 : gap_q + 1;
      insn_start_o <= (gap_q == 0);
      if (gap_q == 0) pc_next_o <= pc_next_o + 15'h1;
      if (pc_load_i) pc_next_o <= pc_value_i;
      pop_valid_o <= 1'b0;
      // Idle return bus toggles so stale data cannot pass
      pop_addr_o <= ~pop_addr_o;
      if (push_valid_i) stack_q.push_back(push_addr_i);
      if (pop_q > 0) pop_q <= pop_q - 1;
      if (pop_req_i) pop_q <= slow_i ? 40 : 1;
      if (pop_q == 1) begin
        pop_valid_o <= 1'b1;
        pop_addr_o <= stack_q.pop_back();
      end
    end
  end
endmodule : mis_core_model

// ### mis_pkg.sv
package mis_pkg;

  // Source count and return address width
  localparam int NUM_SRC = 11;
  localparam int PC_W = 15;

  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ENABLE = 4'h4;
  localparam logic [3:0] ADDR_PENDING = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // Field positions
  localparam int CTRL_GIE_BIT = 0;
  localparam int PEND_TRAP_BIT = 16;
  localparam int STAT_NMI_BIT = 16;
  localparam int STAT_BUSY_BIT = 17;
  localparam int STAT_VEC_LSB = 24;

  // Reset values
  localparam logic RST_GIE = 1'b0;
  localparam logic [NUM_SRC-1:0] RST_ENABLE = 11'h000;
  localparam logic [NUM_SRC-1:0] RST_PENDING = 11'h000;

  // Common handler entry point and vector-select low bytes
  localparam logic [PC_W-1:0] HANDLER_ADDR = 15'h00FF;
  localparam logic [7:0] VEC_TRAP = 8'hFE;
  localparam logic [7:0] VEC_DEFAULT = 8'hE0;
  // Index 0 is the highest-ranked maskable source
  localparam logic [NUM_SRC-1:0][7:0] VEC_TABLE = {
    8'hE2, 8'hEA, 8'hEC, 8'hEE, 8'hF0, 8'hF2,
    8'hF4, 8'hF6, 8'hF8, 8'hFA, 8'hFC
  };

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int INSN_CYCLE_NS = 1000;
  localparam int ACK_INSN_CYCLES = 7;
  localparam int INSN_CLKS = INSN_CYCLE_NS / CLK_PERIOD_NS;
  localparam int ACK_CLKS = ACK_INSN_CYCLES * INSN_CLKS;
  localparam int CNT_W = 10;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACK,
    ST_RET
  } mis_state_e;

endpackage : mis_pkg

// ### mis_sequencer.sv
`timescale 1ns/10ps

// Functional notes
// - Every acknowledged interrupt loads the program counter with 00FF hex.
// - Software trap has top priority; default vector entry has the lowest.
// - Eleven maskable inputs have fixed rank and fixed vector slot.
// - All but the trap are maskable, each with enable and pending bits.
// - A source event sets its pending flag regardless of enables.
// - Maskable trigger needs enable, global enable, and no trap in service.
// - Trigger conditions are evaluated only at instruction start.
// - Highest-ranked qualifying request goes first; others stay pending.
// - Reset clears pending flags, enables and the global enable.
// - Enabling a source with pending flag set makes it active at once.
// - A maskable source is active when enable and pending are both set.
// - A pending skip is performed before any acknowledgment.
// - Starting acknowledgment clears the global enable.
// - Acknowledgment pushes the address of the next instruction.
// - The acknowledgment sequence lasts seven instruction cycles.
// - Writing the processor status word (psw_wr_i) may set global enable, allowing nesting.
// - Return sets global enable, pops the saved address, loads the PC.
// - After return completes, remaining qualifying requests are serviced at the next instruction start.
// - Vector select replaces the PC low byte by an even ranked value.
module mis_sequencer
  import mis_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Peripheral events and software trap
  input wire logic [NUM_SRC-1:0] src_event_i,
  input wire logic trap_i,
  // CPU core side
  input wire logic insn_start_i,
  input wire logic skip_next_i,
  input wire logic [PC_W-1:0] pc_next_i,
  input wire logic psw_wr_i,
  input wire logic psw_gie_i,
  input wire logic vis_exec_i,
  input wire logic return_from_interrupt_i,
  input wire logic pop_valid_i,
  input wire logic [PC_W-1:0] pop_addr_i,
  output logic irq_take_o,
  output logic ack_busy_o,
  output logic push_valid_o,
  output logic [PC_W-1:0] push_addr_o,
  output logic pop_req_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_value_o,
  output logic vis_valid_o,
  output logic [7:0] vis_low_byte_o,
  output logic global_interrupt_enable_o
);

  // Interrupt state
  logic gie_q, gie_d;
  logic [NUM_SRC-1:0] en_q, en_d;
  logic [NUM_SRC-1:0] pend_q, pend_d;
  logic trap_pend_q, trap_pend_d;
  logic nmi_active_q, nmi_active_d;
  mis_state_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  // Core-side output registers
  logic irq_take_q, ack_busy_q, push_valid_q, pop_req_q, pc_load_q;
  logic [PC_W-1:0] push_addr_q, pc_value_q;
  logic vis_valid_q;
  logic [7:0] vis_byte_q;

  // AXI registers
  logic aw_held_q, w_held_q, bvalid_q, awready_q, wready_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Write channel decode
  wire aw_take = s_axi_awvalid_i & awready_q;
  wire w_take = s_axi_wvalid_i & wready_q;
  wire wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  wire aw_held_d = (aw_held_q | aw_take) & ~wr_fire;
  wire w_held_d = (w_held_q | w_take) & ~wr_fire;
  wire bvalid_d = wr_fire | (bvalid_q & ~s_axi_bready_i);
  wire awready_d = ~aw_held_d & ~bvalid_d;
  wire wready_d = ~w_held_d & ~bvalid_d;
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                       {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wbits = w_data_q & wmask;
  wire wr_ctrl = wr_fire & (aw_addr_q == ADDR_CTRL);
  wire wr_enable = wr_fire & (aw_addr_q == ADDR_ENABLE);
  wire wr_pending = wr_fire & (aw_addr_q == ADDR_PENDING);
  wire wr_status = wr_fire & (aw_addr_q == ADDR_STATUS);
  // Status writes are accepted and change nothing
  wire wr_known = wr_ctrl | wr_enable | wr_pending | wr_status;
  // Response is latched with the write and held while bvalid stands
  wire [1:0] bresp_d = wr_fire ? (wr_known ? RESP_OKAY : RESP_SLVERR)
                       : bresp_q;

  // Read channel decode
  wire ar_take = s_axi_arvalid_i & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready_i);
  wire arready_d = ~rvalid_d;

  // Qualification and arbitration
  logic [NUM_SRC-1:0] active;
  logic [NUM_SRC-1:0] pend_clr;
  logic [NUM_SRC-1:0] en_wmask;
  logic mask_any;
  logic [7:0] vis_sel;

  assign pend_clr = wr_pending ? wbits[NUM_SRC-1:0] : '0;
  assign en_wmask = wmask[NUM_SRC-1:0];

  // Pending flags clear only by software; an event wins over the clear
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    assign pend_d[i] = src_event_i[i] | (pend_q[i] & ~pend_clr[i]);
    assign active[i] = en_q[i] & pend_q[i];
    assign en_d[i] = wr_enable & en_wmask[i] ? w_data_q[i] : en_q[i];
  end

  // Lowest index wins; loop runs from lowest rank upward
  always_comb begin
    vis_sel = VEC_DEFAULT;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (active[i]) begin
        vis_sel = VEC_TABLE[i];
      end
    end
    if (trap_pend_q | nmi_active_q) begin
      vis_sel = VEC_TRAP;
    end
  end

  assign mask_any = |active;

  wire trap_clr = wr_pending & wbits[PEND_TRAP_BIT];
  // Boundary gating, skip deferral and qualification
  // A return in the same cycle goes first; the request waits for its end
  wire at_boundary = (state_q == ST_IDLE) & insn_start_i
                     & ~skip_next_i
                     & ~return_from_interrupt_i;
  wire mask_ok = mask_any & gie_q & ~nmi_active_q;
  wire trap_ok = trap_pend_q;
  wire take = at_boundary & (trap_ok | mask_ok);
  wire take_trap = take & trap_ok;
  // A return during an acknowledge is ignored
  wire ret_now = (state_q == ST_IDLE) & return_from_interrupt_i;
  wire ack_end = (state_q == ST_ACK)
                 & (cnt_q == CNT_W'(ACK_CLKS - 1));
  wire ret_done = (state_q == ST_RET) & pop_valid_i;

  // Trap pending: a new trap wins over acknowledgment and software clear
  assign trap_pend_d = trap_i | (trap_pend_q & ~take_trap & ~trap_clr);
  assign nmi_active_d = take_trap | (nmi_active_q & ~ret_now);

  // Global enable: acknowledgment clear has the highest priority
  always_comb begin
    gie_d = gie_q;
    if (take) begin
      gie_d = 1'b0;
    end else if (ret_now) begin
      gie_d = 1'b1;
    end else if (psw_wr_i) begin
      gie_d = psw_gie_i;
    end else if (wr_ctrl & w_strb_q[0]) begin
      gie_d = w_data_q[CTRL_GIE_BIT];
    end
  end

  // Sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        cnt_d = '0;
        if (take) begin
          state_d = ST_ACK;
        end else if (ret_now) begin
          state_d = ST_RET;
        end
      end
      ST_ACK: begin
        cnt_d = cnt_q + CNT_W'(1);
        if (ack_end) begin
          state_d = ST_IDLE;
          cnt_d = '0;
        end
      end
      ST_RET: begin
        if (ret_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Read address decode on the aligned word, as for writes
  wire [3:0] ar_word = {s_axi_araddr_i[3:2], 2'h0};
  wire rd_ctrl = (ar_word == ADDR_CTRL);
  wire rd_enable = (ar_word == ADDR_ENABLE);
  wire rd_pending = (ar_word == ADDR_PENDING);
  wire rd_status = (ar_word == ADDR_STATUS);

  // Read data mux
  logic [31:0] rd_word;
  logic rd_known;
  always_comb begin
    rd_word = '0;
    rd_known = 1'b1;
    if (rd_ctrl) begin
      rd_word[CTRL_GIE_BIT] = gie_q;
    end else if (rd_enable) begin
      rd_word[NUM_SRC-1:0] = en_q;
    end else if (rd_pending) begin
      rd_word[NUM_SRC-1:0] = pend_q;
      rd_word[PEND_TRAP_BIT] = trap_pend_q;
    end else if (rd_status) begin
      rd_word[NUM_SRC-1:0] = active;
      rd_word[STAT_NMI_BIT] = nmi_active_q;
      rd_word[STAT_BUSY_BIT] = (state_q != ST_IDLE);
      rd_word[STAT_VEC_LSB +: 8] = vis_sel;
    end else begin
      rd_known = 1'b0;
    end
  end

  // Interrupt state registers
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gie_q <= RST_GIE;
      en_q <= RST_ENABLE;
      pend_q <= RST_PENDING;
      trap_pend_q <= 1'b0;
      nmi_active_q <= 1'b0;
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      gie_q <= gie_d;
      en_q <= en_d;
      pend_q <= pend_d;
      trap_pend_q <= trap_pend_d;
      nmi_active_q <= nmi_active_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Core-facing outputs
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_take_q <= 1'b0;
      ack_busy_q <= 1'b0;
      push_valid_q <= 1'b0;
      push_addr_q <= '0;
      pop_req_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_value_q <= '0;
      vis_valid_q <= 1'b0;
      vis_byte_q <= VEC_DEFAULT;
    end else begin
      irq_take_q <= take;
      // Busy follows the next state so it drops with the handler jump
      ack_busy_q <= (state_d != ST_IDLE);
      push_valid_q <= take;
      // Return address is taken at the edge that starts the acknowledge
      if (take) begin
        push_addr_q <= pc_next_i;
      end
      pop_req_q <= ret_now;
      pc_load_q <= ack_end | ret_done;
      if (ack_end) begin
        pc_value_q <= HANDLER_ADDR;
      end else if (ret_done) begin
        pc_value_q <= pop_addr_i;
      end
      // Vector byte holds until the next vector select
      vis_valid_q <= vis_exec_i;
      if (vis_exec_i) begin
        vis_byte_q <= vis_sel;
      end
    end
  end

  // AXI write path
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      if (aw_take) begin
        aw_addr_q <= {s_axi_awaddr_i[3:2], 2'h0};
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
    end
  end

  // AXI read path
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign irq_take_o = irq_take_q;
  assign ack_busy_o = ack_busy_q;
  assign push_valid_o = push_valid_q;
  assign push_addr_o = push_addr_q;
  assign pop_req_o = pop_req_q;
  assign pc_load_o = pc_load_q;
  assign pc_value_o = pc_value_q;
  assign vis_valid_o = vis_valid_q;
  assign vis_low_byte_o = vis_byte_q;
  assign global_interrupt_enable_o = gie_q;

endmodule : mis_sequencer

// ### mis_sequencer_asserts.sv
`timescale 1ns/10ps
module mis_sequencer_asserts
  import mis_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic insn_start_i,
  input wire logic skip_next_i,
  input wire logic [PC_W-1:0] pc_next_i,
  input wire logic vis_exec_i,
  input wire logic return_from_interrupt_i,
  input wire logic pop_valid_i,
  input wire logic [PC_W-1:0] pop_addr_i,
  input wire logic irq_take_o,
  input wire logic ack_busy_o,
  input wire logic push_valid_o,
  input wire logic [PC_W-1:0] push_addr_o,
  input wire logic pop_req_o,
  input wire logic pc_load_o,
  input wire logic [PC_W-1:0] pc_value_o,
  input wire logic vis_valid_o,
  input wire logic [7:0] vis_low_byte_o,
  input wire logic global_interrupt_enable_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_ack_open;
    push_valid_o && ack_busy_o && !global_interrupt_enable_o;
  endsequence
  sequence s_ack_close;
    ##[700:700] (pc_load_o && pc_value_o == HANDLER_ADDR && !ack_busy_o);
  endsequence
  a_ack_open: assert property (irq_take_o |-> s_ack_open)
    else $error("ack start without push");
  a_ack_close: assert property (irq_take_o |-> s_ack_close)
    else $error("handler jump wrong");
  a_push_addr: assert property (
    irq_take_o |-> push_addr_o == $past(pc_next_i))
    else $error("pushed address wrong");
  a_take_edge: assert property (
    irq_take_o |-> $past(insn_start_i && !skip_next_i && !ack_busy_o))
    else $error("take off boundary");
  a_busy_ignore: assert property (
    insn_start_i && ack_busy_o |=> !irq_take_o)
    else $error("take while busy");
  a_ret_open: assert property (
    return_from_interrupt_i && !ack_busy_o |=>
    pop_req_o && global_interrupt_enable_o)
    else $error("return start wrong");
  a_ret_load: assert property (
    pop_valid_i && ack_busy_o |=> pc_load_o && pc_value_o == $past(pop_addr_i))
    else $error("return load wrong");
  a_vis_even: assert property (
    vis_exec_i |=> vis_valid_o && !vis_low_byte_o[0] &&
    vis_low_byte_o >= VEC_DEFAULT)
    else $error("vector byte wrong");
endmodule : mis_sequencer_asserts

bind mis_sequencer mis_sequencer_asserts i_mis_sequencer_asserts (
  .ref_clk_i, .reset_i, .insn_start_i, .skip_next_i, .pc_next_i,
  .vis_exec_i, .return_from_interrupt_i, .pop_valid_i, .pop_addr_i,
  .irq_take_o, .ack_busy_o, .push_valid_o, .push_addr_o, .pop_req_o,
  .pc_load_o, .pc_value_o, .vis_valid_o, .vis_low_byte_o,
  .global_interrupt_enable_o
);
